// ==== disk_bus_map.svh ====
// Offsets, field positions, reset values and timing counts for the disk control bus.
`ifndef DISK_BUS_MAP_SVH
`define DISK_BUS_MAP_SVH

`define DCB_CLK_PERIOD_NS 50
`define DCB_DIR_SETUP_NS 200
`define DCB_SETTLE_NS 500
`define DCB_SETTLE_CYC ((`DCB_SETTLE_NS + `DCB_CLK_PERIOD_NS - 1) / `DCB_CLK_PERIOD_NS)

`define DCB_WORD_UNIT 2'h0
`define DCB_WORD_CYL 2'h1
`define DCB_WORD_HEAD 2'h2
`define DCB_WORD_CTRL 2'h3
`define DCB_UNIT_MSB 7
`define DCB_UNIT_LSB 4
`define DCB_FAULT_CLEAR_BIT 4
`define DCB_RW_ERROR_BIT 5
`define DCB_PROT_RESET 3'h0
`define DCB_SERVO_HEAD 5

`define DCB_PMASK_NONE 8'h00
`define DCB_PMASK_H0 8'h01
`define DCB_PMASK_H1 8'h02
`define DCB_PMASK_H2 8'h04
`define DCB_PMASK_H3 8'h08
`define DCB_PMASK_H4 8'h10
`define DCB_PMASK_H0_2 8'h07
`define DCB_PMASK_H0_4 8'h1f

`endif

// ==== disk_bus_pkg.sv ====
// Types shared by the disk control bus drive logic.
package disk_bus_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETTLE = 2'b01,
      ST_HOLD = 2'b10
   } hs_state_t;

endpackage

// ==== protect_decode.sv ====
// Head write-protect code to head mask decoder.
`timescale 1ns/100ps
`include "disk_bus_map.svh"
module protect_decode
   import disk_bus_pkg::*;
#(
   parameter int SERVO_HEAD = `DCB_SERVO_HEAD
) (
   input wire logic [2:0] code_i,
   output logic [7:0] mask_o
);

   if (SERVO_HEAD < 0 || SERVO_HEAD > 7) begin : g_bad_servo
      $error("SERVO_HEAD must lie in 0..7");
   end

   always_comb begin
      case (code_i)
         3'h0: mask_o = `DCB_PMASK_NONE;
         3'h1: mask_o = `DCB_PMASK_H0;
         3'h2: mask_o = `DCB_PMASK_H1;
         3'h3: mask_o = `DCB_PMASK_H2;
         3'h4: mask_o = `DCB_PMASK_H3;
         3'h5: mask_o = `DCB_PMASK_H4;
         3'h6: mask_o = `DCB_PMASK_H0_2;
         default: mask_o = `DCB_PMASK_H0_4;
      endcase
      mask_o[SERVO_HEAD] = 1'b1;
   end

endmodule

// ==== disk_control_bus_handshake.sv ====
// Drive-side control bus handshake, command latch and head write-protect logic.
`timescale 1ns/100ps
`include "disk_bus_map.svh"
module disk_control_bus_handshake
   import disk_bus_pkg::*;
#(
   parameter int SETTLE_CYC = `DCB_SETTLE_CYC,
   parameter int SERVO_HEAD = `DCB_SERVO_HEAD
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic attention_request_i,
   input wire logic direction_i,
   input wire logic word_select_low_i,
   input wire logic word_select_high_i,
   input wire logic [7:0] bus_data_i,
   input wire logic write_enable_i,
   input wire logic [3:0] unit_address_jumper_i,
   input wire logic [2:0] protect_jumper_i,
   input wire logic [7:0] status_word0_i,
   input wire logic [7:0] status_word1_i,
   input wire logic [7:0] status_word2_i,
   input wire logic [7:0] status_word3_i,
   output logic [7:0] bus_data_o,
   output logic bus_data_oe_o,
   output logic cycle_acknowledge_o,
   output logic [3:0] unit_ack_o,
   output logic selected_o,
   output logic drive_fault_o,
   output logic rw_error_o,
   output logic [7:0] command_word0_o,
   output logic [7:0] command_word1_o,
   output logic [7:0] command_word2_o,
   output logic [7:0] command_word3_o,
   output logic fault_clear_o,
   output logic [2:0] protect_code_o,
   output logic head_protected_o
);

   localparam int PIN_W = 20;
   localparam int ACK_MAX = SETTLE_CYC + 2;
   localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

   if (SETTLE_CYC < 1 || SETTLE_CYC > 256) begin : g_bad_settle
      $error("SETTLE_CYC must lie in 1..256");
   end

   // Pin synchroniser: three stages, a bit changes once stages two and three agree.
   logic [PIN_W-1:0] pins;
   logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
   logic [PIN_W-1:0] s1_next, s2_next, s3_next, filt_next;

   assign pins = {attention_request_i, direction_i, word_select_high_i, word_select_low_i,
                  write_enable_i, bus_data_i, unit_address_jumper_i, protect_jumper_i};

   always_comb begin
      s1_next = pins;
      s2_next = s1_reg;
      s3_next = s2_reg;
      filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         filt_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         filt_reg <= filt_next;
      end
   end

   logic attention_request_f, dir_f, we_f;
   logic [1:0] word_f;
   byte_t data_f;
   logic [3:0] unit_f;
   logic [2:0] wpj_f;

   assign attention_request_f = filt_reg[19];
   assign dir_f = filt_reg[18];
   assign word_f = filt_reg[17:16];
   assign we_f = filt_reg[15];
   assign data_f = filt_reg[14:7];
   assign unit_f = filt_reg[6:3];
   assign wpj_f = filt_reg[2:0];

   function automatic byte_t status_pick(input logic [1:0] w, input byte_t s0, input byte_t s1,
                                         input byte_t s2, input byte_t s3);
      case (w)
         2'h0: status_pick = s0;
         2'h1: status_pick = s1;
         2'h2: status_pick = s2;
         default: status_pick = s3;
      endcase
   endfunction

   // Handshake group.
   hs_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic ack_reg, ack_next;
   logic oe_reg, oe_next;
   byte_t dout_reg, dout_next;
   logic exec;
   logic rw_err_reg, rw_err_next;
   byte_t status3;

   assign status3 = status_word3_i | (byte_t'(rw_err_reg) << `DCB_RW_ERROR_BIT);

   logic selected_reg, selected_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ack_next = ack_reg;
      oe_next = oe_reg;
      dout_next = dout_reg;
      exec = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (attention_request_f) begin
               state_next = ST_SETTLE;
               cnt_next = 8'h00;
            end
         end
         ST_SETTLE: begin
            if (!attention_request_f) begin
               state_next = ST_IDLE;
            end else if (cnt_reg == SETTLE_LAST) begin
               state_next = ST_HOLD;
               ack_next = 1'b1;
               if (dir_f) begin
                  exec = 1'b1;
               end else if (selected_reg) begin
                  oe_next = 1'b1;
                  dout_next = status_pick(word_f, status_word0_i, status_word1_i,
                                          status_word2_i, status3);
               end
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         ST_HOLD: begin
            if (!attention_request_f) begin
               state_next = ST_IDLE;
               ack_next = 1'b0;
               oe_next = 1'b0;
            end
         end
         default: begin
            state_next = ST_IDLE;
            ack_next = 1'b0;
            oe_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
         dout_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
         oe_reg <= oe_next;
         dout_reg <= dout_next;
      end
   end

   // Command group. Word 0 is decoded by every drive so that selection can move.
   byte_t cw0_reg, cw1_reg, cw2_reg, cw3_reg;
   byte_t cw0_next, cw1_next, cw2_next, cw3_next;
   logic [2:0] prot_reg, prot_next;
   logic fclr_reg, fclr_next;
   logic fault_reg, fault_next;
   logic [3:0] uack_reg, uack_next;
   logic hprot_reg, hprot_next;
   logic prot_load, exec_sel, prot_now, wp_violation;
   logic [2:0] eff_code;
   logic [7:0] prot_mask;

   assign exec_sel = exec && selected_reg;
   assign prot_load = exec_sel && (word_f == `DCB_WORD_CTRL);

   assign eff_code = (wpj_f != 3'h0) ? wpj_f : prot_reg;

   protect_decode #(
      .SERVO_HEAD(SERVO_HEAD)
   ) u_protect_decode (
      .code_i(eff_code),
      .mask_o(prot_mask)
   );

   assign prot_now = prot_mask[cw2_reg[2:0]];
   assign wp_violation = we_f && selected_reg && prot_now;

   always_comb begin
      cw0_next = cw0_reg;
      cw1_next = cw1_reg;
      cw2_next = cw2_reg;
      cw3_next = cw3_reg;
      prot_next = prot_reg;
      selected_next = selected_reg;
      fclr_next = 1'b0;
      if (exec && (word_f == `DCB_WORD_UNIT)) begin
         cw0_next = data_f;
         selected_next = (data_f[`DCB_UNIT_MSB:`DCB_UNIT_LSB] == unit_f) && (unit_f != 4'h0);
      end
      if (exec_sel && (word_f == `DCB_WORD_CYL)) begin
         cw1_next = data_f;
      end
      if (exec_sel && (word_f == `DCB_WORD_HEAD)) begin
         cw2_next = data_f;
      end
      if (prot_load) begin
         cw3_next = data_f;
         prot_next = data_f[2:0];
         fclr_next = data_f[`DCB_FAULT_CLEAR_BIT];
      end
      uack_next = selected_next ? unit_f : 4'h0;
      hprot_next = prot_now;
      // protected write faults; a new violation wins over a clear
      fault_next = wp_violation || (fault_reg && !fclr_reg);
      rw_err_next = wp_violation || (rw_err_reg && !fclr_reg);
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cw0_reg <= 8'h00;
         cw1_reg <= 8'h00;
         cw2_reg <= 8'h00;
         cw3_reg <= 8'h00;
         prot_reg <= `DCB_PROT_RESET;
         selected_reg <= 1'b0;
         fclr_reg <= 1'b0;
         fault_reg <= 1'b1;
         rw_err_reg <= 1'b0;
         uack_reg <= 4'h0;
         hprot_reg <= 1'b0;
      end else begin
         cw0_reg <= cw0_next;
         cw1_reg <= cw1_next;
         cw2_reg <= cw2_next;
         cw3_reg <= cw3_next;
         prot_reg <= prot_next;
         selected_reg <= selected_next;
         fclr_reg <= fclr_next;
         fault_reg <= fault_next;
         rw_err_reg <= rw_err_next;
         uack_reg <= uack_next;
         hprot_reg <= hprot_next;
      end
   end

   assign bus_data_o = dout_reg;
   assign bus_data_oe_o = oe_reg;
   assign cycle_acknowledge_o = ack_reg;
   assign unit_ack_o = uack_reg;
   assign selected_o = selected_reg;
   assign drive_fault_o = fault_reg;
   assign rw_error_o = rw_err_reg;
   assign command_word0_o = cw0_reg;
   assign command_word1_o = cw1_reg;
   assign command_word2_o = cw2_reg;
   assign command_word3_o = cw3_reg;
   assign fault_clear_o = fclr_reg;
   assign protect_code_o = prot_reg;
   assign head_protected_o = hprot_reg;

   // Checks on the handshake, protect code, servo head, unit acknowledge and write-protect fault.
   sequence s_settle_done;
      state_reg == ST_SETTLE && cnt_reg == SETTLE_LAST && attention_request_f;
   endsequence

   sequence s_attention_request_start;
      state_reg == ST_IDLE && attention_request_f;
   endsequence

   property p_ack_after_settle;
      @(posedge clock_i) disable iff (sys_rst_i)
      $rose(ack_reg) |-> $past(state_reg) == ST_SETTLE && $past(cnt_reg) == SETTLE_LAST;
   endproperty
   a_ack_after_settle: assert property (p_ack_after_settle)
      else $error("acknowledge rose before the settle count ended");

   property p_ack_in_time;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_attention_request_start ##1 attention_request_f [*1] |-> ##[0:ACK_MAX] (ack_reg || !attention_request_f);
   endproperty
   a_ack_in_time: assert property (p_ack_in_time)
      else $error("attention was not acknowledged in time");

   property p_ack_on_done;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_settle_done |=> ack_reg;
   endproperty
   a_ack_on_done: assert property (p_ack_on_done)
      else $error("acknowledge missing after settle with attention high");

   property p_ack_holds;
      @(posedge clock_i) disable iff (sys_rst_i)
      ack_reg && attention_request_f |=> ack_reg;
   endproperty
   a_ack_holds: assert property (p_ack_holds)
      else $error("acknowledge dropped while attention active");

   property p_ack_release;
      @(posedge clock_i) disable iff (sys_rst_i)
      ack_reg && !attention_request_f |=> !ack_reg && !oe_reg;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("acknowledge or bus drive kept after attention dropped");

   property p_no_ack_idle;
      @(posedge clock_i) disable iff (sys_rst_i)
      !attention_request_f && state_reg != ST_HOLD |=> !ack_reg;
   endproperty
   a_no_ack_idle: assert property (p_no_ack_idle)
      else $error("acknowledge without attention");

   property p_drive_selected;
      @(posedge clock_i) disable iff (sys_rst_i)
      $rose(oe_reg) |-> $past(selected_reg) && !$past(dir_f);
   endproperty
   a_drive_selected: assert property (p_drive_selected)
      else $error("bus driven by an unselected drive or on a command cycle");

   property p_prot_load;
      @(posedge clock_i) disable iff (sys_rst_i)
      prot_load |=> prot_reg == $past(data_f[2:0]);
   endproperty
   a_prot_load: assert property (p_prot_load)
      else $error("protect code not loaded from command word 3");

   property p_prot_hold;
      @(posedge clock_i) disable iff (sys_rst_i)
      !prot_load |=> $stable(prot_reg);
   endproperty
   a_prot_hold: assert property (p_prot_hold)
      else $error("protect code changed without command word 3");

   property p_prot_reset;
      @(posedge clock_i) disable iff (sys_rst_i)
      $past(sys_rst_i) |-> prot_reg == `DCB_PROT_RESET;
   endproperty
   a_prot_reset: assert property (p_prot_reset)
      else $error("protect code not cleared by reset");

   property p_jumper_wins;
      @(posedge clock_i) disable iff (sys_rst_i)
      wpj_f != 3'h0 |-> eff_code == wpj_f;
   endproperty
   a_jumper_wins: assert property (p_jumper_wins)
      else $error("programmed code overrode fitted jumpers");

   property p_servo;
      @(posedge clock_i) disable iff (sys_rst_i)
      cw2_reg[2:0] == 3'(SERVO_HEAD) |=> hprot_reg;
   endproperty
   a_servo: assert property (p_servo)
      else $error("servo head not protected");

   property p_unit_ack;
      @(posedge clock_i) disable iff (sys_rst_i)
      selected_reg |-> uack_reg == $past(unit_f);
   endproperty
   a_unit_ack: assert property (p_unit_ack)
      else $error("unit acknowledge does not show own address");

   property p_wp_fault;
      @(posedge clock_i) disable iff (sys_rst_i)
      wp_violation |=> fault_reg && rw_err_reg;
   endproperty
   a_wp_fault: assert property (p_wp_fault)
      else $error("protected write did not raise fault");

endmodule

// ==== disk_ctrl_model.sv ====
// Controller-side model that runs one control bus transfer per task call.
`timescale 1ns/100ps
module disk_ctrl_model (
   input wire logic clock_i,
   input wire logic ack_i,
   input wire logic [7:0] wire_i,
   output logic attention_request_o,
   output logic dir_o,
   output logic [1:0] ws_o,
   output logic [7:0] drv_o
);
   initial begin
      attention_request_o = 1'b0;
      dir_o = 1'b0;
      ws_o = 2'h0;
      drv_o = 8'h00;
   end

   // A negative hold drops attention early, and ok then means no acknowledge came.
   task automatic xfer(input logic d, input logic [1:0] w, input logic [7:0] v,
                       input int hold, output logic [7:0] rd, output logic ok);
      int n;
      ok = 1'b1;
      rd = 8'h00;
      @(posedge clock_i);
      dir_o <= d;
      ws_o <= w;
      drv_o <= d ? v : ~drv_o;
      repeat (4) @(posedge clock_i);
      attention_request_o <= 1'b1;
      if (hold < 0) begin
         repeat (-hold) @(posedge clock_i);
         attention_request_o <= 1'b0;
         repeat (20) begin
            @(posedge clock_i);
            ok = ok & (ack_i !== 1'b1);
         end
      end else begin
         n = 0;
         while (ack_i !== 1'b1 && n < 60) begin
            @(posedge clock_i);
            n++;
         end
         rd = wire_i;
         ok = (n < 60);
         repeat (hold) begin
            @(posedge clock_i);
            ok = ok & (ack_i === 1'b1);
         end
         attention_request_o <= 1'b0;
         n = 0;
         while (ack_i !== 1'b0 && n < 60) begin
            @(posedge clock_i);
            n++;
         end
         ok = ok & (n < 60);
      end
      drv_o <= ~drv_o;
   endtask
endmodule

// ==== disk_control_bus_handshake_bench.sv ====
// Self-checking bench for the drive-side control bus handshake.
`timescale 1ns/100ps
module disk_control_bus_handshake_bench;
   import disk_bus_pkg::*;
   typedef struct {
      logic [1:0] kind;
      logic [1:0] w;
      byte_t v;
      logic sel;
      logic [3:0] ua;
   } note_t;
   localparam logic [7:0] MASKS [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h07, 8'h1f};
   logic clock_i;
   logic sys_rst_i = 1'b1;
   logic we = 1'b0;
   logic [3:0] jmp;
   logic [2:0] pj = 3'h0;
   byte_t st [4];
   logic attention_request, dir, ack, oe, sel_o, dflt, rwe, hp, okk, fclr;
   logic exp_fclr;
   logic [1:0] ws;
   logic [3:0] ua_o;
   logic [2:0] pc;
   byte_t bdo, wire_v, mdrv, rd;
   byte_t cw [4];
   byte_t sh [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic s_sel = 1'b0;
   logic [2:0] s_pc = 3'h0;
   int num_errors = 0;
   int n_tests = 0;
   note_t notes [$];
   note_t cur;
   logic ack_seen = 1'b0;

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // The drive only puts its byte on the wire while its enable is high.
   assign wire_v = oe ? bdo : mdrv;

   disk_control_bus_handshake #(.SETTLE_CYC(4), .SERVO_HEAD(5)) u_disk_control_bus_handshake (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .attention_request_i(attention_request),
      .direction_i(dir), .word_select_low_i(ws[0]), .word_select_high_i(ws[1]),
      .bus_data_i(wire_v), .write_enable_i(we), .unit_address_jumper_i(jmp),
      .protect_jumper_i(pj), .status_word0_i(st[0]), .status_word1_i(st[1]),
      .status_word2_i(st[2]), .status_word3_i(st[3]), .bus_data_o(bdo),
      .bus_data_oe_o(oe), .cycle_acknowledge_o(ack), .unit_ack_o(ua_o),
      .selected_o(sel_o), .drive_fault_o(dflt), .rw_error_o(rwe),
      .command_word0_o(cw[0]), .command_word1_o(cw[1]), .command_word2_o(cw[2]),
      .command_word3_o(cw[3]), .fault_clear_o(fclr), .protect_code_o(pc),
      .head_protected_o(hp));

   disk_ctrl_model u_disk_ctrl_model (
      .clock_i(clock_i), .ack_i(ack), .wire_i(wire_v), .attention_request_o(attention_request),
      .dir_o(dir), .ws_o(ws), .drv_o(mdrv));

   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic go(input logic d, input logic [1:0] w, input byte_t v, input int hold);
      u_disk_ctrl_model.xfer(d, w, v, hold, rd, okk);
      if (okk !== 1'b1) begin
         check("handshake", 8'h01, 8'h00);
         close_out();
      end
   endtask

   task automatic cmd(input logic [1:0] w, input byte_t v);
      if (w == 2'h0) s_sel = (v[7:4] == jmp) && (jmp != 4'h0);
      if (w == 2'h0 || s_sel) sh[w] = v;
      if (w == 2'h3 && s_sel) s_pc = v[2:0];
      notes.push_back('{2'h0, w, sh[w], s_sel, s_sel ? jmp : 4'h0});
      go(1'b1, w, v, 0);
      check("protect_code", 8'(s_pc), 8'(pc));
   endtask

   task automatic stat(input logic [1:0] w, input int hold, input byte_t extra);
      notes.push_back('{s_sel ? 2'h1 : 2'h2, w, st[w] | extra, s_sel, s_sel ? jmp : 4'h0});
      go(1'b0, w, 8'h00, hold);
   endtask

   task automatic head(input logic [2:0] h);
      logic [7:0] m;
      cmd(2'h2, {5'h00, h});
      m = MASKS[(pj != 3'h0) ? pj : s_pc] | 8'h20;
      repeat (2) @(posedge clock_i);
      check("head_protected", 8'(m[h]), 8'(hp));
   endtask

   task automatic reset_chk();
      check("fault_after_reset", 8'h01, 8'(dflt));
      check("protect_after_reset", 8'h00, 8'(pc));
      check("selected_after_reset", 8'h00, 8'(sel_o));
      check("word3_after_reset", 8'h00, cw[3]);
   endtask

   // Each rising acknowledge retires the oldest expected result.
   always @(negedge clock_i) begin
      if (ack === 1'b1 && ack_seen !== 1'b1) begin
         if (notes.size() == 0) begin
            check("note_queue", 8'h01, 8'h00);
         end else begin
            cur = notes.pop_front();
            if (cur.kind == 2'h0) check("command_word", cur.v, cw[cur.w]);
            else check("status_oe", 8'(cur.kind == 2'h1), 8'(oe));
            if (cur.kind == 2'h1) check("status_byte", cur.v, bdo);
            check("selected", 8'(cur.sel), 8'(sel_o));
            check("unit_ack", 8'(cur.ua), 8'(ua_o));
            // The clear pulse stands only in the cycle in which acknowledge rises.
            exp_fclr = (cur.kind == 2'h0) && (cur.w == 2'h3) && cur.sel && cur.v[4];
            check("fault_clear", 8'(exp_fclr), 8'(fclr));
         end
      end
      ack_seen = ack;
   end

   initial begin
      void'($urandom(81));
      jmp = 4'($urandom_range(15, 1));
      foreach (st[i]) st[i] = 8'($urandom);
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      reset_chk();
      stat(2'h1, 0, 8'h00);
      cmd(2'h2, 8'h05);
      cmd(2'h0, {jmp, 4'h3});
      cmd(2'h3, 8'h10);
      check("fault_cleared", 8'h00, 8'(dflt));
      for (int c = 0; c < 8; c++) begin
         cmd(2'h3, (8'($urandom) & 8'he8) | 8'(c));
         cmd(2'h1, 8'($urandom));
         for (int h = 0; h < 6; h++) head(3'(h));
      end
      @(posedge clock_i);
      pj <= 3'($urandom_range(7, 1));
      for (int h = 0; h < 6; h++) head(3'(h));
      @(posedge clock_i);
      pj <= 3'h0;
      cmd(2'h3, 8'h00);
      head(3'h5);
      @(posedge clock_i);
      we <= 1'b1;
      repeat (8) @(posedge clock_i);
      check("fault_set", 8'h01, 8'(dflt));
      check("rw_error_set", 8'h01, 8'(rwe));
      stat(2'h3, 0, 8'h20);
      @(posedge clock_i);
      we <= 1'b0;
      head(3'h1);
      cmd(2'h3, 8'h10);
      check("fault_after_clear", 8'h00, 8'(dflt));
      check("rw_error_after_clear", 8'h00, 8'(rwe));
      @(posedge clock_i);
      we <= 1'b1;
      repeat (8) @(posedge clock_i);
      check("fault_free_head", 8'h00, 8'(dflt));
      we <= 1'b0;
      stat(2'h0, 8, 8'h00);
      go(1'b1, 2'h1, ~sh[1], -3);
      check("word1_after_abort", sh[1], cw[1]);
      cmd(2'h3, 8'h06);
      cmd(2'h0, {jmp ^ 4'h8, 4'h0});
      cmd(2'h3, 8'h07);
      stat(2'h2, 0, 8'h00);
      @(posedge clock_i);
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      s_sel = 1'b0;
      s_pc = 3'h0;
      foreach (sh[i]) sh[i] = 8'h00;
      reset_chk();
      cmd(2'h0, {jmp, 4'h0});
      check("notes_left", 8'h00, 8'(notes.size()));
      close_out();
   end
endmodule
